// File: art_core_if.sv
`timescale 1ns/100ps
`default_nettype none

interface art_core_if;
  logic [7:0] count;
  logic ovfTick;
  modport source (output count, output ovfTick);
  modport sink (input count, input ovfTick);
endinterface

`default_nettype wire

// File: art_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module art_far_side (
  input wire logic clk,
  input wire logic [3:0] pwmOutPin,
  input wire logic [3:0] pwmOutOe,
  input wire logic [1:0] chSel,
  input wire logic cntClr,
  input wire logic extRun,
  input wire logic [1:0] capLevel,
  output logic extClockPin,
  output logic [1:0] capturePin,
  output logic [15:0] highCount
);
  logic [2:0] div_q;
  // source period of eight clocks, well below half the clock rate
  always_ff @(posedge clk) begin
    div_q <= extRun ? div_q + 3'h1 : 3'h0;
    highCount <= cntClr ? 16'h0 : highCount + 16'(pwmOutOe[chSel] & pwmOutPin[chSel]);
  end
  assign extClockPin = div_q[2];
  assign capturePin = capLevel;
endmodule
`default_nettype wire

// File: capture_channel.sv
`timescale 1ns/100ps
`default_nettype none

module capture_channel (
  input wire logic clk,
  input wire logic reset_n,
  art_core_if.sink core,
  input wire logic pinIn,
  input wire logic risingSel,
  input wire logic readClear,
  output logic flag,
  output logic [7:0] value
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;
  wire logic edgeSeen;

  assign edgeSeen = risingSel ? (sync2_q & ~last_q) : (~sync2_q & last_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
      flag <= 1'b0;
      value <= pwm_art_pkg::REG_RESET;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
      // latch is held until software reads it back
      if (edgeSeen && !flag) begin
        value <= core.count;
      end
      flag <= (edgeSeen & ~flag) | (flag & ~readClear) | (edgeSeen & flag);
    end
  end

endmodule

`default_nettype wire

// File: pwm_art_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_art_chk #(
  parameter int PWM_CHANNELS = 4,
  parameter int CAP_CHANNELS = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [PWM_CHANNELS-1:0] pwmOutPin,
  input wire logic [PWM_CHANNELS-1:0] pwmOutOe,
  input wire logic overflowIrq,
  input wire logic [CAP_CHANNELS-1:0] captureIrq
);
  logic rdPend_q, wrPend_q, ovfIe_q;
  logic [7:0] idx_q;
  logic [CAP_CHANNELS-1:0] capIe_q;
  wire logic take = hsel && hready && htrans == pwm_art_pkg::HTRANS_NONSEQ;
  wire logic csrWr = wrPend_q && idx_q == pwm_art_pkg::IDX_TIMER_CSR;
  wire logic capWr = wrPend_q && idx_q == pwm_art_pkg::IDX_CAP_CSR;
  // -----------------------------
  // shadow of enables seen on the bus
  // -----------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPend_q <= 1'b0;
      wrPend_q <= 1'b0;
      idx_q <= 8'h00;
      ovfIe_q <= 1'b0;
      capIe_q <= '0;
    end else begin
      if (hready) begin
        rdPend_q <= take && !hwrite;
        wrPend_q <= take && hwrite;
      end
      if (take) idx_q <= haddr[9:2];
      if (csrWr) ovfIe_q <= hwdata[pwm_art_pkg::CSR_OVF_IE];
      if (capWr) capIe_q <= hwdata[pwm_art_pkg::CAP_IE_LO +: CAP_CHANNELS];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  upper_zero_a: assert property (rdPend_q |-> hrdata[31:8] == 24'h0) else $error("hrdata upper bits set");
  oe_gate_a: assert property ((pwmOutPin & ~pwmOutOe) == '0) else $error("disabled pin driven high");
  oe_follow_a: assert property (wrPend_q && idx_q == pwm_art_pkg::IDX_PWM_CTRL |->
    ##2 pwmOutOe == $past(hwdata[7:4], 2)) else $error("pin enables not as written");
  ovf_irq_gate_a: assert property (overflowIrq |-> ovfIe_q || $past(ovfIe_q))
    else $error("overflow irq while disabled");
  cap_irq_gate_a: assert property ((captureIrq & ~(capIe_q | $past(capIe_q))) == '0)
    else $error("capture irq while disabled");
  cap_rsvd_a: assert property (rdPend_q && idx_q == pwm_art_pkg::IDX_CAP_CSR |-> hrdata[7:6] == 2'b00)
    else $error("reserved capture bits set");
  force_zero_a: assert property (rdPend_q && idx_q == pwm_art_pkg::IDX_TIMER_CSR |-> !hrdata[2])
    else $error("force bit reads one");
endmodule
`default_nettype wire

// File: pwm_art_pkg.sv
package pwm_art_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DUTY_CH3 = 8'h73;
  localparam logic [7:0] IDX_DUTY_CH2 = 8'h74;
  localparam logic [7:0] IDX_DUTY_CH1 = 8'h75;
  localparam logic [7:0] IDX_DUTY_CH0 = 8'h76;
  localparam logic [7:0] IDX_PWM_CTRL = 8'h77;
  localparam logic [7:0] IDX_TIMER_CSR = 8'h78;
  localparam logic [7:0] IDX_COUNTER = 8'h79;
  localparam logic [7:0] IDX_RELOAD = 8'h7A;
  localparam logic [7:0] IDX_CAP_CSR = 8'h7B;
  localparam logic [7:0] IDX_CAP_CH1 = 8'h7C;
  localparam logic [7:0] IDX_CAP_CH2 = 8'h7D;

  localparam int ADDR_LSB = 2;

  // timer control/status fields
  localparam int CSR_EXT_SEL = 7;
  localparam int CSR_PRE_HI = 6;
  localparam int CSR_PRE_LO = 4;
  localparam int CSR_RUN = 3;
  localparam int CSR_FORCE = 2;
  localparam int CSR_OVF_IE = 1;
  localparam int CSR_OVF = 0;

  // pwm control fields
  localparam int PWM_OE_LO = 4;
  localparam int PWM_POL_LO = 0;

  // capture control/status fields
  localparam int CAP_EDGE_LO = 4;
  localparam int CAP_IE_LO = 2;
  localparam int CAP_FLAG_LO = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// File: pwm_autoreload_timer.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_autoreload_timer #(
  parameter int PWM_CHANNELS = 4,
  parameter int CAP_CHANNELS = 2,
  parameter int PRESCALE_BITS = 7
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic extClockPin,
  input wire logic [CAP_CHANNELS-1:0] capturePin,
  output logic [PWM_CHANNELS-1:0] pwmOutPin,
  output logic [PWM_CHANNELS-1:0] pwmOutOe,
  output logic overflowIrq,
  output logic [CAP_CHANNELS-1:0] captureIrq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] duty_q [PWM_CHANNELS];
  logic [7:0] pwmCtrl_q;
  logic extSel_q;
  logic [2:0] prescSel_q;
  logic run_q;
  logic ovfIe_q;
  logic ovfFlag_q;
  logic [7:0] reload_q;
  logic [1:0] capEdge_q;
  logic [1:0] capIe_q;
  logic [7:0] count_q;
  logic [PRESCALE_BITS-1:0] presc_q;
  logic extSync1_q;
  logic extSync2_q;
  logic extLast_q;
  logic wrPend_q;
  logic [7:0] wrIdx_q;
  logic [7:0] rdData_d;

  wire logic [CAP_CHANNELS-1:0] capFlag;
  wire logic [7:0] capValue [CAP_CHANNELS];

  art_core_if core ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic addrPhase;
  wire logic [7:0] reqIdx;
  wire logic rdReq;
  wire logic wrData;
  wire logic [7:0] wByte;

  assign addrPhase = hsel & hready & (htrans == pwm_art_pkg::HTRANS_NONSEQ);
  assign reqIdx = haddr[pwm_art_pkg::ADDR_LSB +: 8];
  assign rdReq = addrPhase & ~hwrite;
  assign wrData = wrPend_q;
  assign wByte = hwdata[7:0];

  wire logic csrWr;
  wire logic cntWr;
  wire logic reloadWr;
  wire logic pwmCtrlWr;
  wire logic capCsrWr;
  wire logic forceWr;
  wire logic csrRd;
  wire logic [CAP_CHANNELS-1:0] capRd;

  assign csrWr = wrData & (wrIdx_q == pwm_art_pkg::IDX_TIMER_CSR);
  assign cntWr = wrData & (wrIdx_q == pwm_art_pkg::IDX_COUNTER);
  assign reloadWr = wrData & (wrIdx_q == pwm_art_pkg::IDX_RELOAD);
  assign pwmCtrlWr = wrData & (wrIdx_q == pwm_art_pkg::IDX_PWM_CTRL);
  assign capCsrWr = wrData & (wrIdx_q == pwm_art_pkg::IDX_CAP_CSR);
  assign forceWr = csrWr & wByte[pwm_art_pkg::CSR_FORCE];
  assign csrRd = rdReq & (reqIdx == pwm_art_pkg::IDX_TIMER_CSR);

  // capture data registers sit at consecutive indices
  genvar r;
  generate
    for (r = 0; r < CAP_CHANNELS; r++) begin : g_cap_rd
      assign capRd[r] = rdReq & (reqIdx == 8'(pwm_art_pkg::IDX_CAP_CH1 + 8'(r)));
    end
  endgenerate

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  wire logic extRise;
  wire logic inputTick;
  wire logic [7:0] tapOne;
  wire logic [PRESCALE_BITS-1:0] prescMask;
  wire logic counterTick;
  wire logic atMax;

  // source edges closer than two clocks apart are lost in the synchroniser
  assign extRise = extSync2_q & ~extLast_q;
  assign inputTick = extSel_q ? extRise : 1'b1;
  assign tapOne = 8'h01 << prescSel_q;
  assign prescMask = PRESCALE_BITS'(tapOne - 8'h01);
  assign counterTick = run_q & inputTick & ((presc_q & prescMask) == prescMask);
  assign atMax = (count_q == pwm_art_pkg::COUNT_MAX);
  // a software load in the same cycle wins over the wrap
  assign core.ovfTick = counterTick & atMax & ~cntWr & ~forceWr;
  assign core.count = count_q;

  logic [7:0] count_d;
  logic [PRESCALE_BITS-1:0] presc_d;

  always_comb begin
    count_d = count_q;
    presc_d = presc_q;
    if (cntWr) begin
      count_d = wByte;
      presc_d = '0;
    end else if (forceWr) begin
      count_d = reload_q;
      presc_d = '0;
    end else begin
      if (run_q && inputTick) begin
        presc_d = presc_q + PRESCALE_BITS'(1);
      end
      if (counterTick) begin
        count_d = atMax ? reload_q : count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= pwm_art_pkg::REG_RESET;
      presc_q <= '0;
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extLast_q <= 1'b0;
    end else begin
      count_q <= count_d;
      presc_q <= presc_d;
      extSync1_q <= extClockPin;
      extSync2_q <= extSync1_q;
      extLast_q <= extSync2_q;
    end
  end

  // ----------------------------------------------------------------
  // control registers and overflow flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwmCtrl_q <= pwm_art_pkg::REG_RESET;
      extSel_q <= 1'b0;
      prescSel_q <= '0;
      run_q <= 1'b0;
      ovfIe_q <= 1'b0;
      reload_q <= pwm_art_pkg::REG_RESET;
      capEdge_q <= '0;
      capIe_q <= '0;
    end else begin
      if (pwmCtrlWr) begin
        pwmCtrl_q <= wByte;
      end
      if (csrWr) begin
        extSel_q <= wByte[pwm_art_pkg::CSR_EXT_SEL];
        prescSel_q <= wByte[pwm_art_pkg::CSR_PRE_HI:pwm_art_pkg::CSR_PRE_LO];
        run_q <= wByte[pwm_art_pkg::CSR_RUN];
        ovfIe_q <= wByte[pwm_art_pkg::CSR_OVF_IE];
      end
      if (reloadWr) begin
        reload_q <= wByte;
      end
      if (capCsrWr) begin
        capEdge_q <= wByte[pwm_art_pkg::CAP_EDGE_LO +: 2];
        capIe_q <= wByte[pwm_art_pkg::CAP_IE_LO +: 2];
      end
    end
  end

  wire logic ovfFlag_d;

  // a wrap in the cycle of the clearing read keeps the flag
  assign ovfFlag_d = core.ovfTick | (ovfFlag_q & ~csrRd);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovfFlag_q <= 1'b0;
    end else begin
      ovfFlag_q <= ovfFlag_d;
    end
  end

  genvar d;
  generate
    for (d = 0; d < PWM_CHANNELS; d++) begin : g_duty
      wire logic dutyWr;
      assign dutyWr = wrData & (wrIdx_q == 8'(pwm_art_pkg::IDX_DUTY_CH0 - 8'(d)));
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          duty_q[d] <= pwm_art_pkg::REG_RESET;
        end else if (dutyWr) begin
          duty_q[d] <= wByte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pwm and capture channels
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PWM_CHANNELS; p++) begin : g_pwm
      pwm_channel u_pwm (
        .clk(clk),
        .reset_n(reset_n),
        .core(core.sink),
        .duty(duty_q[p]),
        .polarity(pwmCtrl_q[pwm_art_pkg::PWM_POL_LO + p]),
        .enable(pwmCtrl_q[pwm_art_pkg::PWM_OE_LO + p]),
        .pwmOut(pwmOutPin[p]),
        .pwmOe(pwmOutOe[p])
      );
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CAP_CHANNELS; c++) begin : g_cap
      capture_channel u_cap (
        .clk(clk),
        .reset_n(reset_n),
        .core(core.sink),
        .pinIn(capturePin[c]),
        .risingSel(capEdge_q[c]),
        .readClear(capRd[c]),
        .flag(capFlag[c]),
        .value(capValue[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [7:0] csrView;
  wire logic [7:0] capCsrView;

  // force bit always reads as zero
  assign csrView = {extSel_q, prescSel_q, run_q, 1'b0, ovfIe_q, ovfFlag_q};
  assign capCsrView = {2'b00, capEdge_q, capIe_q, capFlag};

  always_comb begin
    case (reqIdx)
      pwm_art_pkg::IDX_DUTY_CH3: rdData_d = duty_q[3];
      pwm_art_pkg::IDX_DUTY_CH2: rdData_d = duty_q[2];
      pwm_art_pkg::IDX_DUTY_CH1: rdData_d = duty_q[1];
      pwm_art_pkg::IDX_DUTY_CH0: rdData_d = duty_q[0];
      pwm_art_pkg::IDX_PWM_CTRL: rdData_d = pwmCtrl_q;
      pwm_art_pkg::IDX_TIMER_CSR: rdData_d = csrView;
      pwm_art_pkg::IDX_COUNTER: rdData_d = count_q;
      pwm_art_pkg::IDX_RELOAD: rdData_d = reload_q;
      pwm_art_pkg::IDX_CAP_CSR: rdData_d = capCsrView;
      pwm_art_pkg::IDX_CAP_CH1: rdData_d = capValue[0];
      pwm_art_pkg::IDX_CAP_CH2: rdData_d = capValue[1];
      default: rdData_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  wire logic [31:0] hrdata_d;

  assign hrdata_d = {24'h00_0000, rdData_d};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase) begin
        wrIdx_q <= reqIdx;
      end
      if (rdReq) begin
        hrdata <= hrdata_d;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  wire logic overflowIrq_d;
  wire logic [CAP_CHANNELS-1:0] captureIrq_d;

  assign overflowIrq_d = ovfIe_q & ovfFlag_q;
  assign captureIrq_d = capIe_q & capFlag;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflowIrq <= 1'b0;
      captureIrq <= '0;
    end else begin
      overflowIrq <= overflowIrq_d;
      captureIrq <= captureIrq_d;
    end
  end

endmodule

`default_nettype wire

// File: pwm_channel.sv
`timescale 1ns/100ps
`default_nettype none

module pwm_channel (
  input wire logic clk,
  input wire logic reset_n,
  art_core_if.sink core,
  input wire logic [7:0] duty,
  input wire logic polarity,
  input wire logic enable,
  output logic pwmOut,
  output logic pwmOe
);

  logic [7:0] compareShadow_q;
  wire logic activeLevel;

  // polarity is applied after the compare, so a change shows next edge
  assign activeLevel = (core.count <= compareShadow_q) ^ polarity;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compareShadow_q <= pwm_art_pkg::REG_RESET;
      pwmOut <= 1'b0;
      pwmOe <= 1'b0;
    end else begin
      if (core.ovfTick) begin
        compareShadow_q <= duty;
      end
      pwmOut <= enable & activeLevel;
      pwmOe <= enable;
    end
  end

endmodule

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cntClr = 1'b1, extRun = 1'b0, rdPend = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, chSel = 2'h0, capLevel = 2'h0, capturePin, captureIrq;
  logic hreadyout, hresp, extClockPin, overflowIrq;
  logic [3:0] pwmOutPin, pwmOutOe;
  logic [15:0] highCount;
  logic [7:0] rv;
  logic [31:0] expQ[$];
  int failCount = 0, checks = 0, cycles = 0;
  always #5 clk = ~clk;
  pwm_autoreload_timer i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extClockPin(extClockPin), .capturePin(capturePin), .pwmOutPin(pwmOutPin),
    .pwmOutOe(pwmOutOe), .overflowIrq(overflowIrq), .captureIrq(captureIrq));
  art_far_side i_far (.clk(clk), .pwmOutPin(pwmOutPin), .pwmOutOe(pwmOutOe), .chSel(chSel), .cntClr(cntClr),
    .extRun(extRun), .capLevel(capLevel), .extClockPin(extClockPin), .capturePin(capturePin),
    .highCount(highCount));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (failCount == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= pwm_art_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back({24'h0, exp});
    xfer(idx, 1'b0, 8'h00);
  endtask
  task automatic pwm_count(input logic [1:0] ch, input int n, input int exp);
    chSel <= ch;
    cntClr <= 1'b1;
    @(posedge clk);
    cntClr <= 1'b0;
    repeat (n + 1) @(posedge clk);
    check("pwm high cycles", 32'(highCount), exp);
  endtask
  // -----------------------------
  // read data monitor
  // -----------------------------
  always @(posedge clk) begin
    if (rdPend && hreadyout) check("hrdata", hrdata, expQ.pop_front());
    if (hreadyout) rdPend = hsel && htrans == pwm_art_pkg::HTRANS_NONSEQ && !hwrite;
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      close_out();
    end
  end
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    void'($urandom(22));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 8'h73; i <= 8'h7E; i++) rd(8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      rv = 8'($urandom);
      xfer(8'h73 + 8'(i), 1'b1, rv);
      rd(8'h73 + 8'(i), rv);
    end
    xfer(8'h7B, 1'b1, 8'hFF);
    rd(8'h7B, 8'h3C);
    xfer(8'h7C, 1'b1, 8'hA5);
    rd(8'h7C, 8'h00);
    xfer(8'h78, 1'b1, 8'h06);
    rd(8'h78, 8'h02);
    xfer(8'h79, 1'b1, 8'h5A);
    repeat (20) @(posedge clk);
    rd(8'h79, 8'h5A);
    xfer(8'h7B, 1'b1, 8'h2C);
    capLevel <= 2'b11;
    repeat (8) @(posedge clk);
    rd(8'h7B, 8'h2E);
    capLevel <= 2'b10;
    repeat (8) @(posedge clk);
    rd(8'h7B, 8'h2F);
    check("captureIrq", 32'(captureIrq), 32'h3);
    rd(8'h7C, 8'h5A);
    rd(8'h7B, 8'h2E);
    rd(8'h7D, 8'h5A);
    rd(8'h7B, 8'h2C);
    check("captureIrq", 32'(captureIrq), 32'h0);
    xfer(8'h7A, 1'b1, 8'hFC);
    xfer(8'h78, 1'b1, 8'h04);
    rd(8'h79, 8'hFC);
    for (int c = 0; c < 4; c++) xfer(8'h76 - 8'(c), 1'b1, 8'hFC + 8'(c));
    xfer(8'h77, 1'b1, 8'hF0);
    xfer(8'h78, 1'b1, 8'h0E);
    for (int c = 0; c < 4; c++) begin
      repeat (12) @(posedge clk);
      pwm_count(2'(c), 40, 10 * (c + 1));
    end
    xfer(8'h77, 1'b1, 8'hF1);
    pwm_count(2'h0, 40, 30);
    xfer(8'h77, 1'b1, 8'hE1);
    pwm_count(2'h0, 40, 0);
    for (int n = 1; n < 8; n++) begin
      xfer(8'h78, 1'b1, {1'b0, 3'(n), 4'hA});
      repeat (8 << n) @(posedge clk);
      pwm_count(2'h1, 40 << n, 20 << n);
    end
    xfer(8'h78, 1'b1, 8'h8A);
    extRun <= 1'b1;
    repeat (64) @(posedge clk);
    pwm_count(2'h1, 320, 160);
    extRun <= 1'b0;
    xfer(8'h78, 1'b1, 8'h02);
    repeat (3) @(posedge clk);
    check("overflowIrq", 32'(overflowIrq), 32'h1);
    rd(8'h78, 8'h03);
    rd(8'h78, 8'h02);
    repeat (3) @(posedge clk);
    check("overflowIrq", 32'(overflowIrq), 32'h0);
    close_out();
  end
endmodule
bind pwm_autoreload_timer pwm_art_chk #(.PWM_CHANNELS(PWM_CHANNELS), .CAP_CHANNELS(CAP_CHANNELS)) i_chk (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pwmOutPin(pwmOutPin), .pwmOutOe(pwmOutOe), .overflowIrq(overflowIrq), .captureIrq(captureIrq));
`default_nettype wire
